// ---- core/fafilt_numeric_datapath.sv ----
/*
 * Filter accelerator numeric datapath with sequencer.
 * Assumes a bus master writes samples and coefficients and reads results
 * on the same clock; all strobes are single-cycle and synchronous.
 */
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Signed 24x24 MAC into 48-bit accumulator each cycle of a filter run.
// - ALU input is accumulator bits 46 down to 23.
// - Values are fractions, point after sign bit.
// - Every data value except accumulator and 48-bit product is 24 bits.
// - ALU: add, sub, compare, threshold, abs, squelch, saturate.
// - Seven-field 18-bit control word steers datapath.
// - Sample/coefficient RAMs, routing, shift, hold, rounding.
// - Sixty-four sample and coefficient pairs stored.
// - One 64-tap or four 16-tap filters.
// - One tap per clock during filtering.
module fafilt_numeric_datapath #(
	parameter int TAPS = fafilt_pkg::TAPS
) (
	// Clock, reset, enable
	input  wire logic                          sys_clk,
	input  wire logic                          reset,
	input  wire logic                          clk_en,
	// Configuration
	input  wire logic [fafilt_pkg::CTRL_W-1:0] ctrl_word,
	input  wire logic                          mode_quad,
	// Sample and coefficient writes
	input  wire logic                          sample_wr,
	input  wire fafilt_pkg::fafilt_sample_t    sample_in,
	input  wire logic                          coef_wr,
	input  wire fafilt_pkg::fafilt_coef_t      coef_in,
	// Result read
	input  wire logic                          result_rd,
	output logic [fafilt_pkg::DATA_W-1:0]      result_q,
	output logic                               result_ready_q,
	output logic                               busy_q
);

	localparam int DW = fafilt_pkg::DATA_W;
	localparam int AW = fafilt_pkg::ADDR_W;

	// ==========================================================
	// Storage
	logic signed [DW-1:0] smp_mem [TAPS];
	logic signed [DW-1:0] cof_mem [TAPS];

	fafilt_pkg::fafilt_state_t        state_q, state_d;
	logic [AW-1:0]                    base_q;
	logic [AW-1:0]                    head_q [4];
	logic [AW-1:0]                    tap_q;
	logic [AW-1:0]                    cnt_q;
	logic signed [fafilt_pkg::ACC_W-1:0] acc_q;
	logic signed [DW-1:0]             hold_q;
	logic [AW-1:0]                    last_w;
	logic [AW-1:0]                    wr_addr_w;
	logic [AW-1:0]                    len_mask_w;
	logic [fafilt_pkg::BANK_W-1:0]    bank_w;
	logic [AW-1:0]                    rd_addr_w;
	logic [AW-1:0]                    wr_addr_w_l;
	logic signed [2*DW-1:0]           prod_w;
	logic signed [DW-1:0]             mac_out_w;
	logic signed [DW-1:0]             shifted_w;
	logic signed [DW-1:0]             rounded_w;
	logic signed [DW-1:0]             alu_b_w;
	logic signed [DW-1:0]             alu_w;
	logic signed [DW-1:0]             thr_w;
	fafilt_pkg::fafilt_alu_t          op_w;
	logic [1:0]                       src_w;
	logic [1:0]                       sh_w;
	logic                             start_w;

	// ==========================================================
	// Field decode
	assign op_w  = fafilt_pkg::fafilt_alu_t'(ctrl_word[fafilt_pkg::F_ALU_HI:
		fafilt_pkg::F_ALU_LO]);
	assign src_w = ctrl_word[fafilt_pkg::F_SRC_HI:fafilt_pkg::F_SRC_LO];
	assign sh_w  = ctrl_word[fafilt_pkg::F_SH_HI:fafilt_pkg::F_SH_LO];
	assign thr_w = DW'({ctrl_word[fafilt_pkg::F_THR_HI:fafilt_pkg::F_THR_LO],
		16'h0000});

	// Quad mode splits the store into four 16-entry circular banks.
	assign bank_w     = (mode_quad == fafilt_pkg::MODE_QUAD16) ?
		sample_in.bank : 2'h0;
	assign last_w     = (mode_quad == fafilt_pkg::MODE_QUAD16) ?
		fafilt_pkg::QUAD_LAST : fafilt_pkg::FULL_LAST;
	assign len_mask_w = last_w;
	assign wr_addr_w  = (mode_quad == fafilt_pkg::MODE_QUAD16) ?
		{bank_w, head_q[bank_w][3:0]} : head_q[0];
	assign rd_addr_w  = base_q | ((wr_addr_w_l - tap_q) & len_mask_w);
	assign start_w    = sample_wr && state_q == fafilt_pkg::ST_IDLE;

	// Newest sample position of the filter being computed.
	assign wr_addr_w_l = (mode_quad == fafilt_pkg::MODE_QUAD16) ?
		{2'h0, head_q[base_q[5:4]][3:0] - 4'h1} : head_q[0] - 6'h01;

	// ==========================================================
	// Multiply, select, shift, round, ALU
	assign prod_w    = smp_mem[rd_addr_w] * cof_mem[tap_q | base_q];
	assign mac_out_w = acc_q[fafilt_pkg::ACC_HI:fafilt_pkg::ACC_LO];
	assign shifted_w = mac_out_w >>> sh_w;
	assign rounded_w = ctrl_word[fafilt_pkg::F_RND] && sh_w != 2'h0 ?
		shifted_w + DW'(mac_out_w[sh_w - 2'h1]) : shifted_w;
	assign alu_b_w   = (src_w == 2'h1) ? hold_q :
		(src_w == 2'h2) ? thr_w : DW'(0);

	// Saturating add keeps a fraction from wrapping past full scale.
	function automatic logic signed [DW-1:0] sat_add(
		input logic signed [DW-1:0] a, input logic signed [DW-1:0] b);
		logic signed [DW:0] s;
		s = {a[DW-1], a} + {b[DW-1], b};
		if (s[DW] != s[DW-1])
			sat_add = s[DW] ? {1'b1, {(DW-1){1'b0}}} : {1'b0, {(DW-1){1'b1}}};
		else
			sat_add = s[DW-1:0];
	endfunction

	always_comb begin
		case (op_w)
		fafilt_pkg::ALU_PASS: alu_w = rounded_w;
		fafilt_pkg::ALU_ADD:  alu_w = rounded_w + alu_b_w;
		fafilt_pkg::ALU_SUB:  alu_w = rounded_w - alu_b_w;
		fafilt_pkg::ALU_CMP:  alu_w = (rounded_w > alu_b_w) ? rounded_w : alu_b_w;
		fafilt_pkg::ALU_THR:  alu_w = (rounded_w >= thr_w) ?
			{1'b0, {(DW-1){1'b1}}} : DW'(0);
		fafilt_pkg::ALU_ABS:  alu_w = rounded_w[DW-1] ? -rounded_w : rounded_w;
		fafilt_pkg::ALU_SQL:  alu_w = ((rounded_w[DW-1] ? -rounded_w : rounded_w)
			< thr_w) ? DW'(0) : rounded_w;
		fafilt_pkg::ALU_SAT:  alu_w = sat_add(rounded_w, alu_b_w);
		default:              alu_w = rounded_w;
		endcase
	end

	// ==========================================================
	// Sequencer
	always_comb begin
		state_d = state_q;
		case (state_q)
		fafilt_pkg::ST_IDLE: begin
			if (start_w)
				state_d = fafilt_pkg::ST_MAC;
		end
		fafilt_pkg::ST_MAC: begin
			if (cnt_q == last_w)
				state_d = fafilt_pkg::ST_DONE;
		end
		fafilt_pkg::ST_DONE: state_d = fafilt_pkg::ST_IDLE;
		default:             state_d = fafilt_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state_q        <= fafilt_pkg::ST_IDLE;
			base_q         <= fafilt_pkg::ADDR_ZERO;
			tap_q          <= fafilt_pkg::ADDR_ZERO;
			cnt_q          <= fafilt_pkg::ADDR_ZERO;
			acc_q          <= '0;
			hold_q         <= '0;
			result_q       <= '0;
			result_ready_q <= 1'b0;
			busy_q         <= 1'b0;
			for (int i = 0; i < 4; i++)
				head_q[i] <= fafilt_pkg::ADDR_ZERO;
		end else if (clk_en) begin
			state_q <= state_d;
			busy_q  <= state_d != fafilt_pkg::ST_IDLE;
			if (start_w) begin
				smp_mem[wr_addr_w] <= sample_in.data;
				head_q[bank_w]     <= head_q[bank_w] + 6'h01;
				base_q  <= (mode_quad == fafilt_pkg::MODE_QUAD16) ?
					{bank_w, 4'h0} : fafilt_pkg::ADDR_ZERO;
				tap_q   <= fafilt_pkg::ADDR_ZERO;
				cnt_q   <= fafilt_pkg::ADDR_ZERO;
				acc_q   <= '0;
			end
			if (state_q == fafilt_pkg::ST_MAC) begin
				acc_q <= ctrl_word[fafilt_pkg::F_CLR] && cnt_q == 6'h00 ?
					prod_w : acc_q + prod_w;
				tap_q <= tap_q + 6'h01;
				cnt_q <= cnt_q + 6'h01;
			end
			if (state_q == fafilt_pkg::ST_DONE) begin
				result_q <= alu_w;
				if (!ctrl_word[fafilt_pkg::F_HOLD])
					hold_q <= alu_w;
			end
			// Set wins over a read in the same cycle.
			if (state_q == fafilt_pkg::ST_DONE)
				result_ready_q <= 1'b1;
			else if (result_rd)
				result_ready_q <= 1'b0;
		end
		if (clk_en && coef_wr)
			cof_mem[coef_in.addr] <= coef_in.data;
	end

	// ==========================================================
	// Checks
	logic past_ok;
	always_ff @(posedge sys_clk)
		past_ok <= !reset;

	chk_ready_after_done: assert property (@(posedge sys_clk) disable iff (reset)
		clk_en && state_q == fafilt_pkg::ST_DONE |=> result_ready_q)
		else $error("result flag not raised after done");
	chk_mac_one_tap: assert property (@(posedge sys_clk) disable iff (reset)
		clk_en && state_q == fafilt_pkg::ST_MAC && cnt_q != last_w
		|=> cnt_q == $past(cnt_q) + 6'h01 || !$past(clk_en))
		else $error("tap count did not advance");
	chk_mac_acc: assert property (@(posedge sys_clk) disable iff (reset)
		clk_en && state_q == fafilt_pkg::ST_MAC && cnt_q != 6'h00
		|=> acc_q == $past(acc_q) + $past(prod_w))
		else $error("accumulator did not add product");
	chk_result_slice: assert property (@(posedge sys_clk) disable iff (reset)
		clk_en && state_q == fafilt_pkg::ST_DONE &&
		op_w == fafilt_pkg::ALU_PASS && sh_w == 2'h0
		|=> result_q == $past(mac_out_w))
		else $error("result is not the accumulator slice");
	chk_run_length: assert property (@(posedge sys_clk) disable iff (reset)
		state_q == fafilt_pkg::ST_MAC && mode_quad
		|-> cnt_q <= fafilt_pkg::QUAD_LAST)
		else $error("quad run too long");
	chk_abs_pos: assert property (@(posedge sys_clk) disable iff (reset)
		op_w == fafilt_pkg::ALU_ABS && rounded_w != {1'b1, 23'h000000}
		|-> !alu_w[23])
		else $error("absolute value negative");
	chk_ready_holds: assert property (@(posedge sys_clk) disable iff (reset)
		result_ready_q && !result_rd && state_q != fafilt_pkg::ST_DONE
		|=> result_ready_q)
		else $error("result flag dropped unread");
	chk_busy_start: assert property (@(posedge sys_clk) disable iff (reset)
		clk_en && start_w |=> busy_q ##1 (busy_q || !clk_en))
		else $error("busy not raised on sample");
	chk_frozen: assert property (@(posedge sys_clk) disable iff (reset)
		past_ok && !clk_en |=> $stable(state_q) && $stable(acc_q))
		else $error("state moved while disabled");

	cov_full_run: cover property (@(posedge sys_clk) disable iff (reset)
		start_w && !mode_quad ##[1:80] state_q == fafilt_pkg::ST_DONE);
	cov_quad_run: cover property (@(posedge sys_clk) disable iff (reset)
		start_w && mode_quad ##[1:30] state_q == fafilt_pkg::ST_DONE);
	cov_read: cover property (@(posedge sys_clk) disable iff (reset)
		result_ready_q && result_rd);

endmodule

`default_nettype wire

// ---- inc/fafilt_pkg.sv ----
/*
 * Shared constants and types for the filter accelerator.
 * Assumes a single synchronous clock domain; nothing else.
 */
package fafilt_pkg;

	// ==========================================================
	// Widths
	localparam int DATA_W  = 24;
	localparam int ACC_W   = 48;
	localparam int TAPS    = 64;
	localparam int ADDR_W  = 6;
	localparam int BANK_W  = 2;
	localparam int CTRL_W  = 18;
	localparam int ACC_HI  = 46;
	localparam int ACC_LO  = 23;

	// ==========================================================
	// Control word field layout: seven fields, 18 bits in total.
	// [17:15] alu op, [14:13] source select, [12:11] shift,
	// [10] round, [9] accumulate clear, [8] hold, [7:0] threshold.
	localparam int F_ALU_HI = 17;
	localparam int F_ALU_LO = 15;
	localparam int F_SRC_HI = 14;
	localparam int F_SRC_LO = 13;
	localparam int F_SH_HI  = 12;
	localparam int F_SH_LO  = 11;
	localparam int F_RND    = 10;
	localparam int F_CLR    = 9;
	localparam int F_HOLD   = 8;
	localparam int F_THR_HI = 7;
	localparam int F_THR_LO = 0;
	localparam int THR_SH   = 16;

	// ==========================================================
	// Filter configuration.
	localparam logic [0:0] MODE_FIR64  = 1'h0;
	localparam logic [0:0] MODE_QUAD16 = 1'h1;
	localparam logic [ADDR_W-1:0] QUAD_LAST = 6'h0f;
	localparam logic [ADDR_W-1:0] FULL_LAST = 6'h3f;
	localparam logic [ADDR_W-1:0] ADDR_ZERO = 6'h00;

	typedef enum logic [2:0] {
		ALU_PASS = 3'b000,
		ALU_ADD  = 3'b001,
		ALU_SUB  = 3'b010,
		ALU_CMP  = 3'b011,
		ALU_THR  = 3'b100,
		ALU_ABS  = 3'b101,
		ALU_SQL  = 3'b110,
		ALU_SAT  = 3'b111
	} fafilt_alu_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_MAC  = 2'b01,
		ST_DONE = 2'b10
	} fafilt_state_t;

	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic [BANK_W-1:0] bank;
	} fafilt_sample_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} fafilt_coef_t;

endpackage

// ---- sim/fafilt_bus_model.sv ----
/*
 * Bus master model: loads coefficients, writes samples, reads results.
 * Assumes a single sys_clk domain and drives 1 ns after each rising edge.
 */
`timescale 1ns/1ps
`default_nettype none
module fafilt_bus_model (
	// Status from the block
	input  wire logic                       sys_clk,
	input  wire logic                       busy_q,
	input  wire logic                       result_ready_q,
	input  wire logic [23:0]                result_q,
	// Requests towards the block
	output var  logic                       sample_wr,
	output var  fafilt_pkg::fafilt_sample_t sample_in,
	output var  logic                       coef_wr,
	output var  fafilt_pkg::fafilt_coef_t   coef_in,
	output var  logic                       result_rd
);
	int cyc = 0;
	int tk = 0;

	initial begin
		sample_wr = 1'h0;
		sample_in = '0;
		coef_wr = 1'h0;
		coef_in = '0;
		result_rd = 1'h0;
	end

	always @(posedge sys_clk) cyc <= cyc + 1;

	// ==========================================================
	// Transfers
	task automatic load(input logic [23:0] c [64]);
		for (int a = 0; a < 64; a++) begin
			coef_in = '{addr: 6'(a), data: c[a]};
			coef_wr = 1'h1;
			@(posedge sys_clk) #1;
		end
		coef_wr = 1'h0;
	endtask

	// Waiting for idle keeps samples from being lost while busy.
	task automatic push(input logic [1:0] b, input logic [23:0] d);
		while (busy_q !== 1'h0) @(posedge sys_clk) #1;
		sample_in = '{data: d, bank: b};
		sample_wr = 1'h1;
		@(posedge sys_clk) #1;
		tk = cyc;
		sample_wr = 1'h0;
	endtask

	// Deliberately ignores busy; used only to provoke a refusal.
	task automatic poke(input logic [23:0] d);
		@(posedge sys_clk) #1;
		sample_in = '{data: d, bank: 2'h0};
		sample_wr = 1'h1;
		@(posedge sys_clk) #1;
		sample_wr = 1'h0;
	endtask

	task automatic take(output logic [23:0] r, output int lat);
		while (result_ready_q !== 1'h1) @(posedge sys_clk) #1;
		lat = cyc - tk;
		r = result_q;
		result_rd = 1'h1;
		@(posedge sys_clk) #1;
		result_rd = 1'h0;
	endtask
endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
/*
 * Self-checking bench for the numeric datapath.
 * Assumes the bus model above and a 40 ns sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic                       sys_clk = 1'h0;
	logic                       reset = 1'h1;
	logic                       clk_en = 1'h1;
	logic                       mode_quad = 1'h0;
	logic [17:0]                ctrl_word = 18'h00200;
	logic                       sample_wr;
	logic                       coef_wr;
	logic                       result_rd;
	logic                       result_ready_q;
	logic                       busy_q;
	logic [23:0]                result_q;
	fafilt_pkg::fafilt_sample_t sample_in;
	fafilt_pkg::fafilt_coef_t   coef_in;
	int                         n_mismatch = 0;
	int                         comparisons = 0;
	logic [23:0]                cf [64];
	logic [23:0]                hs [4][64];

	always #20 sys_clk = ~sys_clk;

	fafilt_numeric_datapath #(.TAPS(64)) DUT (.sys_clk(sys_clk),
		.reset(reset), .clk_en(clk_en), .ctrl_word(ctrl_word),
		.mode_quad(mode_quad), .sample_wr(sample_wr),
		.sample_in(sample_in), .coef_wr(coef_wr), .coef_in(coef_in),
		.result_rd(result_rd), .result_q(result_q),
		.result_ready_q(result_ready_q), .busy_q(busy_q));

	fafilt_bus_model bm (.sys_clk(sys_clk), .busy_q(busy_q),
		.result_ready_q(result_ready_q), .result_q(result_q),
		.sample_wr(sample_wr), .sample_in(sample_in), .coef_wr(coef_wr),
		.coef_in(coef_in), .result_rd(result_rd));

	// ==========================================================
	// Checking helpers
	task automatic chk(input logic [23:0] g, input logic [23:0] e);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %0t got %h expected %h", $time, g, e);
		end
	endtask

	// Modular 48-bit sums equal the signed sums, so no sign cast is needed.
	function automatic logic [23:0] model(input int b, input int n);
		logic [47:0] acc;
		logic [47:0] s;
		logic [47:0] c;
		acc = '0;
		for (int k = 0; k < n; k++) begin
			s = {{24{hs[b][k][23]}}, hs[b][k]};
			c = {{24{cf[b*n%64+k][23]}}, cf[b*n%64+k]};
			acc = acc + s * c;
		end
		return acc[46:23];
	endfunction

	// Op 1 expects the absolute value, op 2 a rounded shift by one.
	task automatic run(input int b, input logic [23:0] d, input int n,
			input bit cr, input int frz, input bit pk, input int op);
		logic [23:0] r;
		logic [23:0] e;
		int          lat;
		for (int k = 63; k > 0; k--) hs[b][k] = hs[b][k-1];
		hs[b][0] = d;
		e = model(b, n);
		if (op == 1 && e[23]) e = -e;
		if (op == 2) e = {e[23], e[23:1]} + {23'h0, e[0]};
		bm.push(2'(b), d);
		chk({23'h0, busy_q}, 24'h1);
		if (frz > 0) begin
			clk_en = 1'h0;
			repeat (frz) @(posedge sys_clk);
			#1 clk_en = 1'h1;
		end
		if (pk) bm.poke(24'h5a5a5a);
		bm.take(r, lat);
		chk(24'(lat), 24'(n + 1 + frz));
		chk({23'h0, result_ready_q}, 24'h0);
		if (cr) chk(r, e);
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_full;
		for (int a = 0; a < 64; a++) cf[a] = 24'(a * 1024) - 24'h008000;
		bm.load(cf);
		for (int i = 0; i < 66; i++)
			run(0, 24'(i * 32'h0002f1d3), 64, i > 62, 0, 0, 0);
	endtask

	// A sample offered while busy must leave no trace in the store.
	task automatic t_refuse;
		run(0, 24'h712345, 64, 1, 0, 1, 0);
	endtask

	task automatic t_freeze;
		run(0, 24'h9abcde, 64, 1, 5, 0, 0);
	endtask

	task automatic t_abs;
		ctrl_word = 18'h28200;
		run(0, 24'h812345, 64, 1, 0, 0, 1);
		ctrl_word = 18'h00200;
	endtask

	task automatic t_round;
		ctrl_word = 18'h00e00;
		run(0, 24'h3c0ffe, 64, 1, 0, 0, 2);
		ctrl_word = 18'h00200;
	endtask

	task automatic t_quad;
		mode_quad = 1'h1;
		for (int b = 0; b < 4; b++)
			for (int i = 0; i < 17; i++)
				run(b, 24'(i * 32'h00031337 + b), 16, i > 14, 0, 0, 0);
	endtask

	task results;
		if (n_mismatch == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		#1000000;
		n_mismatch++;
		results();
	end

	initial begin
		repeat (2) @(posedge sys_clk);
		#1 reset = 1'h0;
		chk(result_q, 24'h0);
		chk({22'h0, busy_q, result_ready_q}, 24'h0);
		t_full();
		t_refuse();
		t_freeze();
		t_abs();
		t_round();
		t_quad();
		results();
	end
endmodule
`default_nettype wire
